// ---- logic/cit_addr_form.sv ----
// Address and branch target arithmetic of the sequencer.
`timescale 1ns/1ps
module cit_addr_form (
	input wire logic [15:0] pc_i,
	input wire logic [15:0] data_pointer_i,
	input wire logic [7:0] acc_i,
	input wire logic [7:0] opcode_i,
	input wire logic [7:0] op1_i,
	input wire logic [7:0] rel_i,
	input wire logic [1:0] bytes_i,
	output logic [15:0] seq_pc_o,
	output logic [15:0] code_data_pointer_addr_o,
	output logic [15:0] code_pc_addr_o,
	output logic [15:0] abs_tgt_o,
	output logic [15:0] rel_tgt_o
);
	logic [15:0] pc_next_one;
	logic [15:0] pc_after_two;
	assign seq_pc_o = pc_i + {14'h0000, bytes_i};
	assign pc_next_one = pc_i + 16'h0001;
	assign pc_after_two = pc_i + 16'h0002;
	// The accumulator is an unsigned table index on both bases.
	assign code_data_pointer_addr_o = data_pointer_i + {8'h00, acc_i};
	assign code_pc_addr_o = pc_next_one + {8'h00, acc_i};
	assign abs_tgt_o = {pc_after_two[15:11], opcode_i[7:5], op1_i};
	assign rel_tgt_o = seq_pc_o + {{8{rel_i[7]}}, rel_i};
endmodule : cit_addr_form

// ---- logic/cit_op_decode.sv ----
// Opcode decoder giving length, cycle count, flow and memory class.
`timescale 1ns/1ps
module cit_op_decode (
	input wire logic [7:0] opcode_i,
	output logic [1:0] bytes_o,
	output logic [3:0] cycles_o,
	output cit_pkg::cit_flow_t flow_o,
	output cit_pkg::cit_mem_t mem_o,
	output logic dir_op_o,
	output logic ind_op_o
);
	logic [3:0] hi;
	logic [3:0] lo;
	assign hi = opcode_i[7:4];
	assign lo = opcode_i[3:0];

	always_comb begin
		bytes_o = cit_pkg::LEN_ONE;
		cycles_o = cit_pkg::CYC_ONE;
		flow_o = cit_pkg::FL_SEQ;
		mem_o = cit_pkg::MC_NONE;
		dir_op_o = 1'b0;
		ind_op_o = 1'b0;
		if (lo[3]) begin
			case (hi)
				4'h7: begin bytes_o = cit_pkg::LEN_TWO; cycles_o = cit_pkg::CYC_TWO; end
				4'h8, 4'ha: begin
					bytes_o = cit_pkg::LEN_TWO;
					cycles_o = cit_pkg::CYC_TWO;
					dir_op_o = 1'b1;
				end
				4'hb: begin bytes_o = cit_pkg::LEN_THREE; cycles_o = cit_pkg::CYC_FOUR;
					flow_o = cit_pkg::FL_REL_COND; end
				4'hd: begin bytes_o = cit_pkg::LEN_TWO; cycles_o = cit_pkg::CYC_THREE;
					flow_o = cit_pkg::FL_REL_COND; end
				default: begin end
			endcase
		end else if (lo[3:1] == 3'h3) begin
			ind_op_o = 1'b1;
			cycles_o = cit_pkg::CYC_TWO;
			case (hi)
				4'h7: bytes_o = cit_pkg::LEN_TWO;
				4'h8, 4'ha: begin bytes_o = cit_pkg::LEN_TWO; dir_op_o = 1'b1; end
				4'hb: begin bytes_o = cit_pkg::LEN_THREE; cycles_o = cit_pkg::CYC_FOUR;
					flow_o = cit_pkg::FL_REL_COND; end
				default: begin end
			endcase
		end else begin
			case (lo)
				4'h5: begin
					dir_op_o = (hi != 4'ha);
					bytes_o = (hi == 4'ha) ? cit_pkg::LEN_ONE : cit_pkg::LEN_TWO;
					cycles_o = (hi == 4'ha) ? cit_pkg::CYC_ONE : cit_pkg::CYC_TWO;
					if (hi == 4'h7 || hi == 4'h8) begin
						bytes_o = cit_pkg::LEN_THREE;
						cycles_o = cit_pkg::CYC_THREE;
					end else if (hi == 4'hb || hi == 4'hd) begin
						bytes_o = cit_pkg::LEN_THREE;
						cycles_o = cit_pkg::CYC_FOUR;
						flow_o = cit_pkg::FL_REL_COND;
					end
				end
				4'h4: begin
					if (hi == 4'h8 || hi == 4'ha) cycles_o = cit_pkg::CYC_NINE;
					else if (hi == 4'hd) cycles_o = cit_pkg::CYC_TWO;
					else if (hi == 4'hb) begin bytes_o = cit_pkg::LEN_THREE;
						cycles_o = cit_pkg::CYC_FOUR; flow_o = cit_pkg::FL_REL_COND; end
					else if (hi != 4'h0 && hi != 4'h1 && hi < 4'hc) begin
						bytes_o = cit_pkg::LEN_TWO; cycles_o = cit_pkg::CYC_TWO; end
				end
				4'h3: begin
					case (hi)
						4'h4, 4'h5, 4'h6: begin bytes_o = cit_pkg::LEN_THREE;
							cycles_o = cit_pkg::CYC_THREE; dir_op_o = 1'b1; end
						4'h7: begin cycles_o = cit_pkg::CYC_THREE; flow_o = cit_pkg::FL_IND; end
						4'h8: begin cycles_o = cit_pkg::CYC_FOUR; mem_o = cit_pkg::MC_CODE_PC; end
						4'h9: begin cycles_o = cit_pkg::CYC_FOUR; mem_o = cit_pkg::MC_CODE_DATA_POINTER; end
						4'ha: begin cycles_o = cit_pkg::CYC_THREE; mem_o = cit_pkg::MC_DATA_POINTER_INC; end
						4'he: begin cycles_o = cit_pkg::CYC_FOUR; mem_o = cit_pkg::MC_XRD_PTR; end
						4'hf: begin cycles_o = cit_pkg::CYC_FOUR; mem_o = cit_pkg::MC_XWR_PTR; end
						default: begin end
					endcase
				end
				4'h2: begin
					case (hi)
						4'h0, 4'h1: begin bytes_o = cit_pkg::LEN_THREE;
							cycles_o = cit_pkg::CYC_FOUR; flow_o = cit_pkg::FL_LONG; end
						4'h2, 4'h3: begin cycles_o = cit_pkg::CYC_FOUR; flow_o = cit_pkg::FL_RET; end
						4'he: begin cycles_o = cit_pkg::CYC_FOUR; mem_o = cit_pkg::MC_XRD_PTR; end
						4'hf: begin cycles_o = cit_pkg::CYC_FOUR; mem_o = cit_pkg::MC_XWR_PTR; end
						default: begin bytes_o = cit_pkg::LEN_TWO; cycles_o = cit_pkg::CYC_TWO;
							dir_op_o = (hi < 4'h7); end
					endcase
				end
				4'h1: begin bytes_o = cit_pkg::LEN_TWO; cycles_o = cit_pkg::CYC_THREE;
					flow_o = cit_pkg::FL_ABS; end
				default: begin
					case (hi)
						4'h0: begin end
						4'h1, 4'h2, 4'h3: begin bytes_o = cit_pkg::LEN_THREE;
							cycles_o = cit_pkg::CYC_FOUR;
							if (hi == 4'h1) flow_o = cit_pkg::FL_BIT_CLR;
							else flow_o = cit_pkg::FL_REL_COND;
						end
						4'h4, 4'h5, 4'h6, 4'h7: begin bytes_o = cit_pkg::LEN_TWO;
							cycles_o = cit_pkg::CYC_THREE; flow_o = cit_pkg::FL_REL_COND; end
						4'h8: begin bytes_o = cit_pkg::LEN_TWO; cycles_o = cit_pkg::CYC_THREE;
							flow_o = cit_pkg::FL_REL; end
						4'h9: begin bytes_o = cit_pkg::LEN_THREE; cycles_o = cit_pkg::CYC_THREE;
							mem_o = cit_pkg::MC_DATA_POINTER_LOAD; end
						4'he: begin cycles_o = cit_pkg::CYC_FOUR; mem_o = cit_pkg::MC_XRD_DATA_POINTER; end
						4'hf: begin cycles_o = cit_pkg::CYC_FOUR; mem_o = cit_pkg::MC_XWR_DATA_POINTER; end
						default: begin bytes_o = cit_pkg::LEN_TWO; cycles_o = cit_pkg::CYC_TWO;
							dir_op_o = (hi == 4'hc || hi == 4'hd); end
					endcase
				end
			endcase
		end
	end
endmodule : cit_op_decode

// ---- logic/cit_pkg.sv ----
// Shared constants and types of the instruction timing sequencer.
package cit_pkg;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned CLK_FREQ_HZ = 40_000_000;
	localparam logic [15:0] RESET_PC = 16'h0000;
	localparam logic [15:0] RESET_DATA_POINTER = 16'h0000;
	localparam logic [15:0] EXTENDED_RAM_TOP = 16'h07ff;
	localparam logic [7:0] SFR_BASE = 8'h80;
	localparam logic [3:0] CYC_ONE = 4'h1;
	localparam logic [3:0] CYC_TWO = 4'h2;
	localparam logic [3:0] CYC_THREE = 4'h3;
	localparam logic [3:0] CYC_FOUR = 4'h4;
	localparam logic [3:0] CYC_NINE = 4'h9;
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;
	localparam logic [3:0] OPERAND1_CYC = 4'h1;
	localparam logic [3:0] OPERAND2_CYC = 4'h2;
	localparam logic [3:0] MEM_CYC = 4'h1;

	typedef enum logic [2:0] {
		FL_SEQ = 3'h0, FL_ABS = 3'h1, FL_LONG = 3'h2, FL_REL = 3'h3,
		FL_REL_COND = 3'h4, FL_BIT_CLR = 3'h5, FL_IND = 3'h6, FL_RET = 3'h7
	} cit_flow_t;

	typedef enum logic [3:0] {
		MC_NONE = 4'h0, MC_CODE_DATA_POINTER = 4'h1, MC_CODE_PC = 4'h2, MC_XRD_DATA_POINTER = 4'h3,
		MC_XRD_PTR = 4'h4, MC_XWR_DATA_POINTER = 4'h5, MC_XWR_PTR = 4'h6, MC_DATA_POINTER_LOAD = 4'h7,
		MC_DATA_POINTER_INC = 4'h8
	} cit_mem_t;

	typedef enum logic {ST_FETCH = 1'b0, ST_EXEC = 1'b1} cit_state_t;
endpackage : cit_pkg

// ---- logic/cit_sequencer.sv ----
// Instruction fetch and execution timing sequencer of the metering core.
`timescale 1ns/1ps
module cit_sequencer #(
	parameter int unsigned EXTENDED_RAM_AW = 11
) (
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic [7:0] CODE_DATA_I,
	input wire logic [7:0] ACC_I,
	input wire logic [7:0] PTR_REG_I,
	input wire logic COND_I,
	input wire logic [15:0] RET_ADDR_I,
	output logic [15:0] CODE_ADDR_O,
	output logic INSTR_START_O,
	output logic INSTR_DONE_O,
	output logic [1:0] INSTR_BYTES_O,
	output logic [3:0] INSTR_CYCLES_O,
	output logic [7:0] OPCODE_O,
	output logic [7:0] OPERAND1_O,
	output logic [7:0] OPERAND2_O,
	output logic [15:0] PC_O,
	output logic [15:0] DATA_POINTER_O,
	output logic [7:0] CODE_BYTE_O,
	output logic CODE_BYTE_VALID_O,
	output logic [10:0] EXTENDED_RAM_ADDR_O,
	output logic EXTENDED_RAM_RD_O,
	output logic EXTENDED_RAM_WR_O,
	output logic DIRECT_SFR_O,
	output logic IND_RAM_O,
	output logic BIT_CLEAR_O
);
	if (EXTENDED_RAM_AW != 11) begin : g_bad_aw
		$error("cit_sequencer: EXTENDED_RAM_AW must be 11");
	end

	cit_pkg::cit_state_t state_r;
	logic [3:0] cyc_r;
	logic [15:0] pc_r;
	logic [15:0] data_pointer_r;
	logic [7:0] opc_r;
	logic [7:0] op1_r;
	logic [7:0] op2_r;
	logic [7:0] code_byte_r;
	logic code_valid_r;
	logic [10:0] xaddr_r;
	logic xrd_r;
	logic xwr_r;
	logic sfr_r;
	logic ind_r;
	logic bclr_r;

	logic fetching;
	logic [7:0] cur_opc;
	logic [3:0] cur_cyc;
	logic last_cyc;
	logic [1:0] dec_bytes;
	logic [3:0] dec_cycles;
	cit_pkg::cit_flow_t dec_flow;
	cit_pkg::cit_mem_t dec_mem;
	logic dec_dir;
	logic dec_ind;
	logic [7:0] rel_byte;
	logic [15:0] seq_pc;
	logic [15:0] code_data_pointer_addr;
	logic [15:0] code_pc_addr;
	logic [15:0] abs_tgt;
	logic [15:0] rel_tgt;
	logic [15:0] pc_nxt;
	logic [15:0] xaddr_full;
	logic extended_ram_access;

	assign fetching = (state_r == cit_pkg::ST_FETCH);
	// Decoding the live code byte in the fetch cycle lets one-cycle instructions finish there.
	assign cur_opc = fetching ? CODE_DATA_I : opc_r;
	assign cur_cyc = fetching ? 4'h0 : cyc_r;
	assign last_cyc = (cur_cyc == dec_cycles - 4'h1);
	assign rel_byte = (dec_bytes == cit_pkg::LEN_THREE) ? op2_r : op1_r;

	cit_op_decode u_decode (
		.opcode_i(cur_opc),
		.bytes_o(dec_bytes),
		.cycles_o(dec_cycles),
		.flow_o(dec_flow),
		.mem_o(dec_mem),
		.dir_op_o(dec_dir),
		.ind_op_o(dec_ind)
	);

	cit_addr_form u_addr (
		.pc_i(pc_r),
		.data_pointer_i(data_pointer_r),
		.acc_i(ACC_I),
		.opcode_i(cur_opc),
		.op1_i(op1_r),
		.rel_i(rel_byte),
		.bytes_i(dec_bytes),
		.seq_pc_o(seq_pc),
		.code_data_pointer_addr_o(code_data_pointer_addr),
		.code_pc_addr_o(code_pc_addr),
		.abs_tgt_o(abs_tgt),
		.rel_tgt_o(rel_tgt)
	);

	// The code port serves the opcode first, then operand bytes or at most one table read.
	always_comb begin
		CODE_ADDR_O = pc_r + {12'h000, cur_cyc};
		if (cur_cyc == cit_pkg::MEM_CYC && dec_mem == cit_pkg::MC_CODE_DATA_POINTER) begin
			CODE_ADDR_O = code_data_pointer_addr;
		end else if (cur_cyc == cit_pkg::MEM_CYC && dec_mem == cit_pkg::MC_CODE_PC) begin
			CODE_ADDR_O = code_pc_addr;
		end
	end

	always_comb begin
		case (dec_flow)
			cit_pkg::FL_ABS: pc_nxt = abs_tgt;
			cit_pkg::FL_LONG: pc_nxt = {op1_r, op2_r};
			cit_pkg::FL_REL: pc_nxt = rel_tgt;
			cit_pkg::FL_REL_COND: pc_nxt = COND_I ? rel_tgt : seq_pc;
			cit_pkg::FL_BIT_CLR: pc_nxt = COND_I ? rel_tgt : seq_pc;
			cit_pkg::FL_IND: pc_nxt = code_data_pointer_addr;
			cit_pkg::FL_RET: pc_nxt = RET_ADDR_I;
			default: pc_nxt = seq_pc;
		endcase
	end

	// Sequencing state: a new opcode is taken only after the last listed cycle.
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_r <= cit_pkg::ST_FETCH;
			cyc_r <= 4'h0;
		end else if (last_cyc) begin
			state_r <= cit_pkg::ST_FETCH;
			cyc_r <= 4'h0;
		end else begin
			state_r <= cit_pkg::ST_EXEC;
			cyc_r <= cur_cyc + 4'h1;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			pc_r <= cit_pkg::RESET_PC;
		end else if (last_cyc) begin
			pc_r <= pc_nxt;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			opc_r <= 8'h00;
			op1_r <= 8'h00;
			op2_r <= 8'h00;
		end else begin
			if (fetching) begin
				opc_r <= CODE_DATA_I;
			end
			if (cur_cyc == cit_pkg::OPERAND1_CYC && dec_bytes != cit_pkg::LEN_ONE) begin
				op1_r <= CODE_DATA_I;
			end
			if (cur_cyc == cit_pkg::OPERAND2_CYC && dec_bytes == cit_pkg::LEN_THREE) begin
				op2_r <= CODE_DATA_I;
			end
		end
	end

	// The low data pointer byte is taken straight off the code port in the last cycle.
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			data_pointer_r <= cit_pkg::RESET_DATA_POINTER;
		end else if (last_cyc && dec_mem == cit_pkg::MC_DATA_POINTER_LOAD) begin
			data_pointer_r <= {op1_r, CODE_DATA_I};
		end else if (last_cyc && dec_mem == cit_pkg::MC_DATA_POINTER_INC) begin
			data_pointer_r <= data_pointer_r + 16'h0001;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			code_byte_r <= 8'h00;
			code_valid_r <= 1'b0;
		end else begin
			code_valid_r <= 1'b0;
			if (cur_cyc == cit_pkg::MEM_CYC &&
			    (dec_mem == cit_pkg::MC_CODE_DATA_POINTER || dec_mem == cit_pkg::MC_CODE_PC)) begin
				code_byte_r <= CODE_DATA_I;
				code_valid_r <= 1'b1;
			end
		end
	end

	assign xaddr_full = (dec_mem == cit_pkg::MC_XRD_PTR || dec_mem == cit_pkg::MC_XWR_PTR) ?
		{8'h00, PTR_REG_I} : data_pointer_r;
	// Only extended moves may load the address register, so it holds between accesses.
	assign extended_ram_access = (cur_cyc == cit_pkg::MEM_CYC) && (xaddr_full <= cit_pkg::EXTENDED_RAM_TOP) &&
		(dec_mem == cit_pkg::MC_XRD_PTR || dec_mem == cit_pkg::MC_XRD_DATA_POINTER ||
		dec_mem == cit_pkg::MC_XWR_PTR || dec_mem == cit_pkg::MC_XWR_DATA_POINTER);

	// Addresses above the on-chip range are dropped; there is no external space to reach.
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			xaddr_r <= 11'h000;
			xrd_r <= 1'b0;
			xwr_r <= 1'b0;
		end else begin
			xrd_r <= extended_ram_access &&
				(dec_mem == cit_pkg::MC_XRD_PTR || dec_mem == cit_pkg::MC_XRD_DATA_POINTER);
			xwr_r <= extended_ram_access &&
				(dec_mem == cit_pkg::MC_XWR_PTR || dec_mem == cit_pkg::MC_XWR_DATA_POINTER);
			if (extended_ram_access) begin
				xaddr_r <= xaddr_full[10:0];
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			sfr_r <= 1'b0;
			ind_r <= 1'b0;
		end else begin
			if (fetching) begin
				ind_r <= dec_ind;
				sfr_r <= 1'b0;
			end
			if (cur_cyc == cit_pkg::OPERAND1_CYC) begin
				sfr_r <= dec_dir && (CODE_DATA_I >= cit_pkg::SFR_BASE);
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			bclr_r <= 1'b0;
		end else begin
			bclr_r <= last_cyc && dec_flow == cit_pkg::FL_BIT_CLR && COND_I;
		end
	end

	assign INSTR_START_O = fetching;
	assign INSTR_DONE_O = last_cyc;
	assign INSTR_BYTES_O = dec_bytes;
	assign INSTR_CYCLES_O = dec_cycles;
	assign OPCODE_O = opc_r;
	assign OPERAND1_O = op1_r;
	assign OPERAND2_O = op2_r;
	assign PC_O = pc_r;
	assign DATA_POINTER_O = data_pointer_r;
	assign CODE_BYTE_O = code_byte_r;
	assign CODE_BYTE_VALID_O = code_valid_r;
	assign EXTENDED_RAM_ADDR_O = xaddr_r;
	assign EXTENDED_RAM_RD_O = xrd_r;
	assign EXTENDED_RAM_WR_O = xwr_r;
	assign DIRECT_SFR_O = sfr_r;
	assign IND_RAM_O = ind_r;
	assign BIT_CLEAR_O = bclr_r;

	// Helper count of cycles since the current instruction was fetched.
	logic [3:0] span_r;
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			span_r <= 4'h0;
		end else if (INSTR_DONE_O) begin
			span_r <= 4'h0;
		end else begin
			span_r <= span_r + 4'h1;
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);

	sequence s_start(logic [7:0] op);
		INSTR_START_O && CODE_DATA_I == op;
	endsequence

	sequence s_hold_then_done(int n);
		(!INSTR_DONE_O) [*1] ##1 INSTR_DONE_O;
	endsequence

	a_exact_span: assert property (INSTR_DONE_O |-> span_r + 4'h1 == INSTR_CYCLES_O)
		else $error("instruction ended off its cycle count");
	a_reg_add_one: assert property (INSTR_START_O && CODE_DATA_I[7:3] == 5'h05
		|-> INSTR_DONE_O && INSTR_BYTES_O == 2'h1)
		else $error("register add not one byte one cycle");
	a_swap_one: assert property (s_start(8'hc4) |-> INSTR_DONE_O ##1 INSTR_START_O)
		else $error("accumulator swap not one cycle");
	a_ind_two: assert property (s_start(8'h26) |-> !INSTR_DONE_O ##1 INSTR_DONE_O)
		else $error("pointer add not two cycles");
	a_imm_two: assert property (s_start(8'h24) |-> INSTR_BYTES_O == 2'h2 ##1 INSTR_DONE_O
		##1 PC_O == $past(PC_O, 2) + 16'h0002)
		else $error("immediate add length or timing wrong");
	a_dir_imm_three: assert property (s_start(8'h53) |-> !INSTR_DONE_O ##1 !INSTR_DONE_O
		##1 INSTR_DONE_O)
		else $error("logic into direct byte not three cycles");
	a_data_pointer_load: assert property (s_start(8'h90) ##2 INSTR_DONE_O
		|=> DATA_POINTER_O == {OPERAND1_O, $past(CODE_DATA_I)})
		else $error("data pointer load wrong");
	a_code_byte_read_index: assert property (s_start(8'h93) |=> CODE_ADDR_O == DATA_POINTER_O +
		{8'h00, ACC_I} ##2 INSTR_DONE_O)
		else $error("code byte read address or timing wrong");
	a_extended_ram_four: assert property (s_start(8'he0) |-> ##3 INSTR_DONE_O)
		else $error("extended move not four cycles");
	a_extended_ram_range: assert property ((EXTENDED_RAM_RD_O || EXTENDED_RAM_WR_O) |-> $past(cur_cyc) == 4'h1
		&& $past(xaddr_full) <= cit_pkg::EXTENDED_RAM_TOP)
		else $error("extended strobe out of place");
	a_push_two: assert property (s_start(8'hc0) |-> s_hold_then_done(2))
		else $error("push not two cycles");
	a_long_jump: assert property (s_start(8'h02) |-> ##3 INSTR_DONE_O
		##1 PC_O == {OPERAND1_O, OPERAND2_O})
		else $error("long jump target or timing wrong");
	a_jbc_clear: assert property (INSTR_DONE_O && !INSTR_START_O && OPCODE_O == 8'h10
		&& COND_I |=> BIT_CLEAR_O)
		else $error("bit not cleared on branch");
	a_compare_jump_unequal_four: assert property (s_start(8'hb4) |-> ##3 INSTR_DONE_O)
		else $error("compare jump not four cycles");
	a_decrement_jump_nonzero_reg: assert property (s_start(8'hd8) |-> ##2 INSTR_DONE_O)
		else $error("register decrement jump not three cycles");
	a_dir_move_three: assert property (s_start(8'h85) |-> ##2 INSTR_DONE_O)
		else $error("direct to direct move not three cycles");
	a_xch_dir: assert property (s_start(8'hc5) |-> !INSTR_DONE_O ##1 INSTR_DONE_O)
		else $error("exchange with direct byte not two cycles");
	a_carry_one: assert property (s_start(8'hc3) |-> INSTR_DONE_O)
		else $error("carry clear not one cycle");
	a_ind_jump: assert property (s_start(8'h73) |-> ##2 INSTR_DONE_O)
		else $error("indirect jump not three cycles");
	a_abs_jump: assert property (s_start(8'h01) |-> INSTR_BYTES_O == 2'h2 ##2 INSTR_DONE_O)
		else $error("absolute jump length or timing wrong");
	a_short_jump: assert property (s_start(8'h80) |-> INSTR_BYTES_O == 2'h2 ##2 INSTR_DONE_O)
		else $error("short jump length or timing wrong");
endmodule : cit_sequencer

// ---- verification/cit_sequencer_tb_top.sv ----
// Self-checking bench that runs a straight-line program through the timing sequencer.
`timescale 1ns/1ps
module cit_sequencer_tb_top;
	localparam int N = 59;
	// Each word holds opcode, two operand bytes, length and cycle count.
	// Branches use a zero offset, so taken or not the next opcode follows directly.
	localparam logic [31:0] PROG [N] = '{
		32'h90000433, 32'h93000014, 32'h73000013,
		32'h28000011, 32'h26000012, 32'h25800022, 32'h24330022,
		32'h53123433, 32'h43123433, 32'h63123433, 32'ha3000013,
		32'he4000011, 32'hc4000011, 32'h13000011, 32'h83000014,
		32'he0000014, 32'hf0000014, 32'he2000014, 32'hf2000014,
		32'hc0120022, 32'hd0120022, 32'h85801033, 32'h857f1033,
		32'h75905533, 32'hc6000012, 32'hd6000012, 32'hc5300022,
		32'hc3000011, 32'hd3000011, 32'hb3000011, 32'hc2080022,
		32'ha2080022, 32'h72080022, 32'h06000012, 32'h15400022,
		32'h01000023, 32'h11000023, 32'h80000023, 32'h40000023,
		32'h50000023, 32'h60000023, 32'h70000023, 32'hd8000023,
		32'h02000034, 32'h12000034, 32'h20080034, 32'h30080034,
		32'h10080034, 32'h10080034, 32'hb5400034, 32'hb4550034,
		32'hb8550034, 32'hb6550034, 32'hd5400034, 32'h9007ff33,
		32'he0000014, 32'h90080033, 32'he0000014, 32'hf0000014
	};
	logic clk, rst_b, cond;
	logic [7:0] acc, ptr_reg, opc, op1, op2, cbyte;
	logic [15:0] ret_addr, code_addr, pc, data_pointer, epc;
	logic start, done, cbv, rd, wr, special_function_register, ind, bclr;
	logic [1:0] bytes;
	logic [3:0] cycles;
	logic [10:0] xaddr;
	logic [7:0] rom [0:4095];
	logic [31:0] prog_w [N];
	int err_total = 0;
	int samples_checked = 0;
	wire [7:0] code_data = rom[code_addr[11:0]];

	cit_sequencer #(.EXTENDED_RAM_AW(11)) dut (.CLK_I(clk), .RST_B_I(rst_b), .CODE_DATA_I(code_data),
		.ACC_I(acc), .PTR_REG_I(ptr_reg), .COND_I(cond), .RET_ADDR_I(ret_addr),
		.CODE_ADDR_O(code_addr), .INSTR_START_O(start), .INSTR_DONE_O(done),
		.INSTR_BYTES_O(bytes), .INSTR_CYCLES_O(cycles), .OPCODE_O(opc), .OPERAND1_O(op1),
		.OPERAND2_O(op2), .PC_O(pc), .DATA_POINTER_O(data_pointer), .CODE_BYTE_O(cbyte),
		.CODE_BYTE_VALID_O(cbv), .EXTENDED_RAM_ADDR_O(xaddr), .EXTENDED_RAM_RD_O(rd), .EXTENDED_RAM_WR_O(wr),
		.DIRECT_SFR_O(special_function_register), .IND_RAM_O(ind), .BIT_CLEAR_O(bclr));

	always #12.5 clk = ~clk;

	task automatic report_and_stop();
		if (err_total == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input logic c);
		@(posedge clk);
		cond <= c;
		#1;
	endtask : tick

	// Walks one instruction from its fetch cycle to the fetch cycle of the next one.
	task automatic run_one(input int k);
		logic [31:0] w;
		logic [7:0] op;
		logic [15:0] ta, xa;
		logic xok, xop, tbl;
		int idx;
		w = prog_w[k];
		op = w[31:24];
		tbl = op == 8'h83 || op == 8'h93;
		ta = ((op == 8'h93) ? data_pointer : epc + 16'h0001) + {8'h00, acc};
		xa = (op == 8'he2 || op == 8'hf2) ? {8'h00, ptr_reg} : data_pointer;
		xok = xa <= 16'h07ff;
		xop = op inside {8'he0, 8'he2, 8'hf0, 8'hf2};
		chk(pc, epc);
		chk(16'(bytes), 16'(w[7:4]));
		chk(16'(cycles), 16'(w[3:0]));
		for (idx = 0; idx < 12; idx++) begin
			chk(16'(start), 16'(idx == 0));
			chk(16'(rd), 16'(xop && xok && !op[4] && idx == 2));
			chk(16'(wr), 16'(xop && xok && op[4] && idx == 2));
			chk(16'(cbv), 16'(tbl && idx == 2));
			if (idx == 1) chk(16'(opc), 16'(op));
			if (idx == 1 && tbl) chk(code_addr, ta);
			if (idx == 2 && tbl) chk(16'(cbyte), 16'(rom[ta[11:0]]));
			if (idx == 2 && xop && xok) chk(16'(xaddr), 16'(xa[10:0]));
			if (idx == 1 && op inside {8'h26, 8'h06, 8'hc6, 8'hd6}) chk(16'(ind), 16'h1);
			if (idx == 2 && (op == 8'h85 || op == 8'h75)) chk(16'(special_function_register), 16'(w[23]));
			if (done === 1'b1) break;
			tick(k[0]);
		end
		if (idx == 12) begin
			err_total++;
			report_and_stop();
		end
		chk(16'(idx + 1), 16'(w[3:0]));
		tick(~k[0]);
		chk(16'(bclr), 16'(op == 8'h10 && k[0]));
		if (op == 8'h28) chk(16'(ind), 16'h0);
		if (w[7:4] > 4'h1) chk(16'(op1), 16'(w[23:16]));
		if (w[7:4] > 4'h2) chk(16'(op2), 16'(w[15:8]));
		if (op == 8'h90) chk(data_pointer, w[23:8]);
		epc = epc + 16'(w[7:4]);
	endtask : run_one

	initial begin
		logic [31:0] w;
		logic [15:0] a;
		clk = 1'b0;
		rst_b = 1'b0;
		cond = 1'b0;
		acc = 8'h01;
		ptr_reg = 8'h5a;
		ret_addr = 16'h0000;
		epc = 16'h0000;
		a = 16'h0000;
		for (int i = 0; i < 4096; i++) rom[i] = 8'h00;
		// Jump targets are filled in so that every jump lands on the next opcode.
		for (int k = 0; k < N; k++) begin
			w = PROG[k];
			if (w[31:24] == 8'h01 || w[31:24] == 8'h11) w[23:16] = a[7:0] + 8'h02;
			if (w[31:24] == 8'h02 || w[31:24] == 8'h12) w[23:8] = a + 16'h0003;
			prog_w[k] = w;
			rom[a[11:0]] = w[31:24];
			if (w[7:4] > 4'h1) rom[a[11:0] + 12'h001] = w[23:16];
			if (w[7:4] > 4'h2) rom[a[11:0] + 12'h002] = w[15:8];
			a = a + 16'(w[7:4]);
		end
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		for (int k = 0; k < N; k++) run_one(k);
		report_and_stop();
	end
endmodule : cit_sequencer_tb_top
